// ==== core/e1ssm_sa_access.sv ====
// E1 national and international overhead bit access with status events.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
module e1ssm_sa_access
  import e1ssm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              rxLineData,
  input  wire logic              rxLineStrobe,
  input  wire logic              rxMfSync,
  input  wire logic              txLineStrobe,
  input  wire logic              txPayload,
  input  wire logic              txLinkDataPin,
  output logic                   txLineData,
  output logic                   txLinkClockPin,
  output logic                   rxLinkDataPin,
  output logic                   rxLinkClockPin,
  output logic                   irq
);
  //////////////////////////////////////////////////////////////////////////////
  localparam int IN_RXD = 0;
  localparam int IN_RXS = 1;
  localparam int IN_RXM = 2;
  localparam int IN_TXS = 3;
  localparam int IN_TXL = 4;
  localparam int IN_TXP = 5;

  logic [5:0] meta_ff;
  logic [5:0] sync_ff;
  logic [1:0] edge_ff;
  logic       rxStb;
  logic       txStb;
  logic       rxBit;
  logic       txLinkSync;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_ff <= 6'h00;
      sync_ff <= 6'h00;
      edge_ff <= 2'h0;
    end else begin
      meta_ff <= {txPayload, txLinkDataPin, txLineStrobe, rxMfSync, rxLineStrobe, rxLineData};
      sync_ff <= meta_ff;
      edge_ff <= {sync_ff[IN_TXS], sync_ff[IN_RXS]};
    end
  end

  assign rxStb      = sync_ff[IN_RXS] & ~edge_ff[0];
  assign txStb      = sync_ff[IN_TXS] & ~edge_ff[1];
  assign rxBit      = sync_ff[IN_RXD];
  assign txLinkSync = sync_ff[IN_TXL];

  // Maps a timeslot-0 bit to its overhead slot; bit 3 of the result is valid.
  function automatic logic [3:0] ohSlot(input logic odd, input logic [2:0] k);
    logic [3:0] r;
    r = 4'h0;
    if (!odd) begin
      r = {(k == SI_POS), OH_SIAF};
    end else if (k != FIX_POS) begin
      r = {1'b1, (k == SI_POS) ? OH_SINAF : k};
    end
    return r;
  endfunction

  function automatic logic isOh(input logic [ADDR_W-1:0] a, input logic [2:0] blk);
    return a[7:5] == blk;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  logic [3:0] rxFrame;
  logic [7:0] rxPos;
  logic [3:0] txFrame;
  logic [7:0] txPos;

  e1ssm_frame_cnt #(.BIT_W(8), .FRAME_W(4)) rxCnt (
    .clk      (clk),
    .rstn     (rstn),
    .strobe   (rxStb),
    .syncIn   (sync_ff[IN_RXM]),
    .frameNum (rxFrame),
    .bitNum   (rxPos)
  );

  e1ssm_frame_cnt #(.BIT_W(8), .FRAME_W(4)) txCnt (
    .clk      (clk),
    .rstn     (rstn),
    .strobe   (txStb),
    .syncIn   (1'b0),
    .frameNum (txFrame),
    .bitNum   (txPos)
  );

  logic       rxTs0;
  logic       txTs0;
  logic [2:0] rxK;
  logic [2:0] txK;
  logic       rxMfEnd;
  logic       rxAfEnd;
  logic       txMfEnd;
  logic       txAfEnd;
  logic [3:0] rxSlot;

  assign rxTs0   = rxPos[7:3] == 5'h00;
  assign txTs0   = txPos[7:3] == 5'h00;
  assign rxK     = rxPos[2:0];
  assign txK     = txPos[2:0];
  assign rxMfEnd = rxStb && rxFrame == LAST_FRAME && rxPos == LAST_BIT;
  assign rxAfEnd = rxStb && rxFrame[0] && rxPos == LAST_BIT;
  assign txMfEnd = txStb && txFrame == LAST_FRAME && txPos == LAST_BIT;
  assign txAfEnd = txStb && txFrame[0] && txPos == LAST_BIT;
  assign rxSlot  = ohSlot(rxFrame[0], rxK);

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] rxShadow_ff [8];
  logic [7:0] rxOh_ff     [8];
  logic [7:0] rxNafShadow_ff;
  logic [7:0] rxNaf_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        rxShadow_ff[i] <= RST_REG;
      end
    end else if (rxStb && rxTs0 && rxSlot[3]) begin
      rxShadow_ff[rxSlot[2:0]] <= {rxShadow_ff[rxSlot[2:0]][6:0], rxBit};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        rxOh_ff[i] <= RST_REG;
      end
    end else if (rxMfEnd) begin
      for (int i = 0; i < 8; i++) begin
        rxOh_ff[i] <= rxShadow_ff[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rxNafShadow_ff <= RST_NAF;
      rxNaf_ff       <= RST_NAF;
    end else begin
      if (rxStb && rxTs0 && rxFrame[0]) begin
        rxNafShadow_ff <= {rxNafShadow_ff[6:0], rxBit};
      end
      if (rxAfEnd) begin
        rxNaf_ff <= rxNafShadow_ff;
      end
    end
  end

  logic       ts16One_ff;
  logic [1:0] ts16Zeros_ff;
  logic       inTs16;

  assign inTs16 = rxStb && rxPos >= TS16_FIRST && rxPos <= TS16_LAST;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ts16One_ff   <= 1'b0;
      ts16Zeros_ff <= 2'h0;
    end else if (rxMfEnd) begin
      ts16One_ff   <= 1'b0;
      ts16Zeros_ff <= 2'h0;
    end else if (inTs16) begin
      ts16One_ff <= ts16One_ff | rxBit;
      if (!rxBit && ts16Zeros_ff != ONES_LIMIT) begin
        ts16Zeros_ff <= ts16Zeros_ff + 2'h1;
      end
    end
  end

  logic [7:0] rxCtl2_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rxLinkDataPin  <= 1'b1;
      rxLinkClockPin <= 1'b0;
    end else begin
      if (rxStb) begin
        rxLinkDataPin <= rxBit;
      end
      rxLinkClockPin <= rxStb && rxTs0 && rxFrame[0] && rxK >= SA_FIRST && rxCtl2_ff[rxK];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] txOh_ff     [8];
  logic [7:0] txShadow_ff [8];
  logic [7:0] txNaf_ff;
  logic [7:0] txNafSmp_ff;
  logic [7:0] txCtl2_ff;
  logic [7:0] insCtl_ff;
  logic [3:0] txSlot;
  logic [2:0] txSel;
  logic       nxt_txLine;

  assign txSlot = ohSlot(1'b1, txK);
  assign txSel  = ~txFrame[3:1];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        txShadow_ff[i] <= RST_REG;
      end
      txNafSmp_ff <= RST_NAF;
    end else begin
      if (txMfEnd) begin
        for (int i = 0; i < 8; i++) begin
          txShadow_ff[i] <= txOh_ff[i];
        end
      end
      if (txAfEnd) begin
        txNafSmp_ff <= txNaf_ff;
      end
    end
  end

  always_comb begin
    nxt_txLine = sync_ff[IN_TXP];
    if (!txTs0) begin
      nxt_txLine = sync_ff[IN_TXP];
    end else if (!txFrame[0]) begin
      if (txK == SI_POS) begin
        nxt_txLine = insCtl_ff[~OH_SIAF] ? txShadow_ff[OH_SIAF][txSel] : 1'b1;
      end else begin
        nxt_txLine = FAS_BITS[~txK];
      end
    end else if (txK >= SA_FIRST && txCtl2_ff[txK]) begin
      nxt_txLine = txLinkSync;
    end else if (txK == FIX_POS) begin
      nxt_txLine = 1'b1;
    end else if (insCtl_ff[~txSlot[2:0]]) begin
      nxt_txLine = txShadow_ff[txSlot[2:0]][txSel];
    end else begin
      nxt_txLine = txNafSmp_ff[~txK];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      txLineData     <= 1'b1;
      txLinkClockPin <= 1'b0;
    end else begin
      if (txStb) begin
        txLineData <= nxt_txLine;
      end
      txLinkClockPin <= txStb && txTs0 && txFrame[0] && txK >= SA_FIRST && txCtl2_ff[txK];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [6:0] status_ff;
  logic [6:0] mask_ff;
  logic [6:0] evt;
  logic [6:0] clr;
  logic       awHeld_ff;
  logic       wHeld_ff;
  logic [7:0] awAddr_ff;
  logic [7:0] wData_ff;
  logic       wLane_ff;
  logic       doWr;
  logic       wrOn;

  assign evt = {rxMfEnd && ts16Zeros_ff != ONES_LIMIT, rxMfEnd && !ts16One_ff,
                txMfEnd, txAfEnd, rxMfEnd, rxMfEnd, rxAfEnd};
  assign doWr = awHeld_ff && wHeld_ff && !bvalid;
  assign wrOn = doWr && wLane_ff;
  assign clr  = (wrOn && awAddr_ff == ADDR_STATUS) ? wData_ff[6:0] : 7'h00;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_ff <= 7'h00;
      irq       <= 1'b0;
    end else begin
      status_ff <= (status_ff & ~clr) | evt;
      irq       <= |(status_ff & mask_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_ff   <= 7'h00;
      rxCtl2_ff <= RST_REG;
      txCtl2_ff <= RST_REG;
      insCtl_ff <= RST_REG;
      txNaf_ff  <= RST_NAF;
      for (int i = 0; i < 8; i++) begin
        txOh_ff[i] <= RST_REG;
      end
    end else if (wrOn) begin
      case (awAddr_ff)
        ADDR_MASK:   mask_ff   <= wData_ff[6:0];
        ADDR_RXCTL2: rxCtl2_ff <= wData_ff;
        ADDR_TXCTL2: txCtl2_ff <= wData_ff;
        ADDR_INSCTL: insCtl_ff <= wData_ff;
        ADDR_TXNAF:  txNaf_ff  <= wData_ff;
        default: begin
          if (isOh(awAddr_ff, TXOH_BLOCK)) begin
            txOh_ff[awAddr_ff[4:2]] <= wData_ff;
          end
        end
      endcase
    end
  end

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_STATUS || a == ADDR_MASK || a == ADDR_RXCTL2 || a == ADDR_TXCTL2 ||
           a == ADDR_INSCTL || a == ADDR_RXNAF || a == ADDR_TXNAF ||
           isOh(a, RXOH_BLOCK) || isOh(a, TXOH_BLOCK);
  endfunction

  always_ff @(posedge clk) begin
    if (!rstn) begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff  <= 8'h00;
      wLane_ff  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= {awaddr[ADDR_W-1:2], 2'h0};
        awready   <= 1'b0;
      end else if (!awHeld_ff && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= wdata[7:0];
        wLane_ff <= wstrb[0];
        wready   <= 1'b0;
      end else if (!wHeld_ff && !bvalid) begin
        wready <= 1'b1;
      end
      if (doWr) begin
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= isMapped(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  logic [7:0] rdByte;

  always_comb begin
    rdByte = 8'h00;
    case ({araddr[ADDR_W-1:2], 2'h0})
      ADDR_STATUS: rdByte = {1'b0, status_ff};
      ADDR_MASK:   rdByte = {1'b0, mask_ff};
      ADDR_RXCTL2: rdByte = rxCtl2_ff;
      ADDR_TXCTL2: rdByte = txCtl2_ff;
      ADDR_INSCTL: rdByte = insCtl_ff;
      ADDR_RXNAF:  rdByte = rxNaf_ff;
      ADDR_TXNAF:  rdByte = txNaf_ff;
      default: begin
        if (isOh(araddr, RXOH_BLOCK)) begin
          rdByte = rxOh_ff[araddr[4:2]];
        end else if (isOh(araddr, TXOH_BLOCK)) begin
          rdByte = txOh_ff[araddr[4:2]];
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rdByte};
      rresp   <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_rx_align_event: assert property (
    @(posedge clk) disable iff (!rstn) rxAfEnd |=> status_ff[ST_RX_ALIGN])
    else $error("Receive align event not flagged.");

  a_rx_mf_events: assert property (
    @(posedge clk) disable iff (!rstn) rxMfEnd |=> status_ff[ST_RX_CRC_MF] && status_ff[ST_RX_MF])
    else $error("Receive multiframe events not flagged.");

  a_tx_events: assert property (
    @(posedge clk) disable iff (!rstn) txMfEnd |=> status_ff[ST_TX_MF] && status_ff[ST_TX_ALIGN])
    else $error("Transmit multiframe events not flagged.");

  a_rx_reload: assert property (
    @(posedge clk) disable iff (!rstn) rxMfEnd |=> rxOh_ff[3] == $past(rxShadow_ff[3]))
    else $error("Receive Sa4 register not reloaded.");

  a_tx_sample: assert property (
    @(posedge clk) disable iff (!rstn) txMfEnd |=> txShadow_ff[7] == $past(txOh_ff[7]))
    else $error("Transmit Sa8 register not sampled.");

  a_tx_first_bit: assert property (
    @(posedge clk) disable iff (!rstn)
    txStb && txTs0 && txFrame == 4'h1 && txK == SA_FIRST && !txCtl2_ff[3] && insCtl_ff[4]
    |=> txLineData == $past(txShadow_ff[3][7]))
    else $error("Frame 1 Sa4 bit is not the register MSB.");

  a_tx_link_over: assert property (
    @(posedge clk) disable iff (!rstn)
    txStb && txTs0 && txFrame[0] && txK >= SA_FIRST && txCtl2_ff[txK]
    |=> txLineData == $past(txLinkSync) ##1 txLinkClockPin == 1'b0)
    else $error("Link-selected Sa bit not taken from link pin.");

  a_rx_link_clk: assert property (
    @(posedge clk) disable iff (!rstn) rxLinkClockPin |-> $past(rxStb) && $past(rxFrame[0]))
    else $error("Receive link clock outside an Sa bit.");

  a_irq_gate: assert property (
    @(posedge clk) disable iff (!rstn) $past(rstn) |-> irq == $past(|(status_ff & mask_ff)))
    else $error("Interrupt disagrees with masked status.");

  a_sig_zeros_set: assert property (
    @(posedge clk) disable iff (!rstn) rxMfEnd && !ts16One_ff |=> status_ff[ST_SIG_ZEROS])
    else $error("All-zero timeslot 16 not flagged.");
endmodule

// ==== core/e1ssm_pkg.sv ====
// Shared constants for the E1 overhead-bit access block.
package e1ssm_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_MASK   = 8'h20;
  localparam logic [7:0] ADDR_RXCTL2 = 8'h24;
  localparam logic [7:0] ADDR_TXCTL2 = 8'h28;
  localparam logic [7:0] ADDR_INSCTL = 8'h2C;
  localparam logic [7:0] ADDR_RXNAF  = 8'h30;
  localparam logic [7:0] ADDR_TXNAF  = 8'h34;
  localparam logic [2:0] RXOH_BLOCK  = 3'h2;
  localparam logic [2:0] TXOH_BLOCK  = 3'h3;
  // Status field positions.
  localparam int ST_RX_ALIGN  = 0;
  localparam int ST_RX_CRC_MF = 1;
  localparam int ST_RX_MF     = 2;
  localparam int ST_TX_ALIGN  = 3;
  localparam int ST_TX_MF     = 4;
  localparam int ST_SIG_ZEROS = 5;
  localparam int ST_SIG_ONES  = 6;
  // Overhead array slots: align Si, non-align Si, remote alarm, then Sa4 to Sa8.
  localparam logic [2:0] OH_SIAF  = 3'h0;
  localparam logic [2:0] OH_SINAF = 3'h1;
  localparam logic [2:0] SA_FIRST = 3'h3;
  localparam logic [2:0] SI_POS   = 3'h0;
  localparam logic [2:0] FIX_POS  = 3'h1;
  // Reset values.
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [7:0] RST_NAF  = 8'hFF;
  // Frame layout.
  localparam logic [7:0] FAS_BITS   = 8'h1B;
  localparam logic [7:0] LAST_BIT   = 8'hFF;
  localparam logic [3:0] LAST_FRAME = 4'hF;
  localparam logic [7:0] TS16_FIRST = 8'h80;
  localparam logic [7:0] TS16_LAST  = 8'h87;
  localparam logic [1:0] ONES_LIMIT = 2'h3;
  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== core/e1ssm_frame_cnt.sv ====
// Bit and frame position counter over a sixteen-frame multiframe.
`timescale 1ns/10ps
module e1ssm_frame_cnt
  import e1ssm_pkg::*;
#(
  parameter int BIT_W   = 8,
  parameter int FRAME_W = 4
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               strobe,
  input  wire logic               syncIn,
  output logic [FRAME_W-1:0]      frameNum,
  output logic [BIT_W-1:0]        bitNum
);
  logic [FRAME_W+BIT_W-1:0] cnt_ff;
  logic [FRAME_W+BIT_W-1:0] pos;

  // A sync marks the present bit as bit 0 of frame 0.
  assign pos = syncIn ? '0 : cnt_ff;
  assign {frameNum, bitNum} = pos;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else if (strobe) begin
      cnt_ff <= pos + 1'b1;
    end
  end
endmodule

// ==== sim/e1ssm_line_model.sv ====
// Remote E1 framer model that drives the receive line and watches the transmit line.
`timescale 1ns/10ps
module e1ssm_line_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ts16Zero,
  input  wire logic [7:0] rxCode,
  input  wire logic       txLineData,
  input  wire logic       txLinkClockPin,
  output logic            rxLineData,
  output logic            rxLineStrobe,
  output logic            rxMfSync,
  output logic            txLineStrobe,
  output logic            txPayload,
  output logic            txLinkDataPin,
  output logic [4:0][7:0] txSaSeen,
  output logic [3:0]      txMfCount
);
  logic [2:0]  phase;
  logic [11:0] idx;
  logic [11:0] prv;
  logic        started;
  logic [7:0]  fas;

  assign prv = idx - 12'h001;
  assign fas = 8'h9B;

  // Frame byte layout: even frames carry the align word, odd frames Si, 1, A, Sa4 to Sa8.
  function automatic logic line_bit(input logic [11:0] i);
    if (i[7:0] >= 8'h80 && i[7:0] <= 8'h87) return ~ts16Zero;
    if (i[7:0] > 8'h07) return i[0] ^ i[8];
    if (!i[8]) return fas[3'h7 - i[2:0]];
    if (i[7:0] == 8'h03) return rxCode[3'h7 - i[11:9]];
    return i[7:0] != 8'h02;
  endfunction

  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase <= 3'h0;
      idx <= 12'h000;
      started <= 1'h0;
      rxLineStrobe <= 1'h0;
      txLineStrobe <= 1'h0;
      rxMfSync <= 1'h0;
      rxLineData <= 1'h1;
      txPayload <= 1'h0;
      txLinkDataPin <= 1'h0;
      txSaSeen <= '0;
      txMfCount <= 4'h0;
    end else begin
      phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
      if (txLinkClockPin) txLinkDataPin <= ~txLinkDataPin;
      if (phase == 3'h0) begin
        rxLineStrobe <= 1'h1;
        txLineStrobe <= 1'h1;
        rxLineData <= line_bit(idx);
        rxMfSync <= (idx == 12'h000);
        txPayload <= idx[1];
        idx <= idx + 12'h001;
        started <= 1'h1;
        if (started && prv[8] && prv[7:3] == 5'h00 && prv[2:0] >= 3'h3) begin
          txSaSeen[prv[2:0] - 3'h3][3'h7 - prv[11:9]] <= txLineData;
        end
        if (started && prv == 12'hFFF) txMfCount <= txMfCount + 4'h1;
      end
      if (phase == 3'h3) begin
        rxLineStrobe <= 1'h0;
        txLineStrobe <= 1'h0;
        rxMfSync <= 1'h0;
      end
      // The line is not held past its sampling window.
      if (phase == 3'h4) rxLineData <= ~rxLineData;
    end
  end
endmodule

// ==== sim/tb_e1ssm_sa_access.sv ====
// Self-checking testbench for the E1 overhead-bit access block.
`timescale 1ns/10ps
module tb_e1ssm_sa_access
  import e1ssm_pkg::*;
;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] care;
    logic [1:0]  resp;
  } e1ssm_note_type;
  logic clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, irq, rxLineData, rxLineStrobe, rxMfSync, txLineStrobe, txPayload;
  logic txLinkDataPin, txLineData, txLinkClockPin, rxLinkDataPin, rxLinkClockPin, ts16Zero;
  logic [7:0]      awaddr, araddr, rxCode, txCode, linkShift;
  logic [31:0]     wdata, rdata;
  logic [3:0]      wstrb, txMfCount;
  logic [1:0]      bresp, rresp;
  logic [4:0][7:0] txSaSeen;
  int              errors, checks, linkPulses;
  logic [31:0]     seed;
  e1ssm_note_type  note;
  e1ssm_note_type  notes[$];
  logic [1:0]      bNotes[$];

  e1ssm_sa_access e1ssm_sa_access_inst (.clk(clk), .rstn(rstn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rxLineData(rxLineData), .rxLineStrobe(rxLineStrobe),
    .rxMfSync(rxMfSync), .txLineStrobe(txLineStrobe), .txPayload(txPayload),
    .txLinkDataPin(txLinkDataPin), .txLineData(txLineData), .txLinkClockPin(txLinkClockPin),
    .rxLinkDataPin(rxLinkDataPin), .rxLinkClockPin(rxLinkClockPin), .irq(irq));

  e1ssm_line_model e1ssm_line_model_inst (.clk(clk), .rstn(rstn), .ts16Zero(ts16Zero),
    .rxCode(rxCode), .txLineData(txLineData), .txLinkClockPin(txLinkClockPin),
    .rxLineData(rxLineData), .rxLineStrobe(rxLineStrobe), .rxMfSync(rxMfSync),
    .txLineStrobe(txLineStrobe), .txPayload(txPayload), .txLinkDataPin(txLinkDataPin),
    .txSaSeen(txSaSeen), .txMfCount(txMfCount));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Values sampled at a falling edge hold until the next rising edge takes them.
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic awHit, wHit, bHit;
    int   n;
    n = 0;
    bHit = 1'h0;
    bNotes.push_back(er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!bHit && n < 100) begin
      @(negedge clk);
      awHit = awvalid & awready;
      wHit = wvalid & wready;
      bHit = bvalid & bready;
      n++;
      @(posedge clk);
      if (awHit) awvalid <= 1'h0;
      if (wHit) wvalid <= 1'h0;
      if (bHit) bready <= 1'h0;
    end
    if (!bHit) errors++;
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] c,
                          input logic [1:0] er);
    logic arHit, rHit;
    int   n;
    n = 0;
    rHit = 1'h0;
    notes.push_back('{exp: e, care: c, resp: er});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!rHit && n < 100) begin
      @(negedge clk);
      arHit = arvalid & arready;
      rHit = rvalid & rready;
      n++;
      @(posedge clk);
      if (arHit) arvalid <= 1'h0;
      if (rHit) rready <= 1'h0;
    end
    if (!rHit) errors++;
  endtask

  always @(negedge clk) begin
    if (rvalid && rready) begin
      note = notes.pop_front();
      check(rdata & note.care, note.exp);
      check({30'h0, rresp}, {30'h0, note.resp});
    end
    if (bvalid && bready) begin
      check({30'h0, bresp}, {30'h0, bNotes.pop_front()});
    end
    if (rxLinkClockPin) begin
      linkPulses++;
      linkShift = {linkShift[6:0], rxLinkDataPin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial begin
    #5000000;
    errors++;
    test_done();
  end

  initial begin
    int n;
    int i;
    seed = 32'd15752;
    rstn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, ts16Zero} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    errors = 0;
    checks = 0;
    linkPulses = 0;
    linkShift = 8'h00;
    rxCode = next_rand();
    txCode = next_rand();
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    repeat (2) @(posedge clk);
    axi_read(ADDR_STATUS, 32'h0, 32'hFF, RESP_OKAY);
    axi_read(ADDR_MASK, {24'h0, RST_REG}, 32'hFF, RESP_OKAY);
    axi_read(ADDR_TXNAF, {24'h0, RST_NAF}, 32'hFF, RESP_OKAY);
    axi_read(8'h10, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    axi_write(8'h14, 8'hFF, RESP_SLVERR);
    axi_write(ADDR_MASK, 8'h02, RESP_OKAY);
    axi_write(ADDR_RXCTL2, 8'h08, RESP_OKAY);
    axi_write(ADDR_TXCTL2, 8'h10, RESP_OKAY);
    axi_write({TXOH_BLOCK, 3'h3, 2'h0}, txCode, RESP_OKAY);
    axi_write({TXOH_BLOCK, 3'h4, 2'h0}, 8'h00, RESP_OKAY);
    axi_write({TXOH_BLOCK, 3'h7, 2'h0}, 8'h00, RESP_OKAY);
    axi_write(ADDR_INSCTL, 8'h18, RESP_OKAY);
    axi_read({TXOH_BLOCK, 3'h3, 2'h0}, {24'h0, txCode}, 32'hFF, RESP_OKAY);
    n = 0;
    while (irq !== 1'h1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    check({31'h0, irq}, 32'h1);
    for (i = 0; i < 8; i++) begin
      axi_read({RXOH_BLOCK, i[2:0], 2'h0},
               (i == 2) ? 32'h0 : (i == 3) ? {24'h0, rxCode} : 32'hFF, 32'hFF, RESP_OKAY);
    end
    axi_read(ADDR_RXNAF, {24'h0, 3'h6, rxCode[0], 4'hF}, 32'hFF, RESP_OKAY);
    axi_read(ADDR_STATUS, 32'h4F, 32'h6F, RESP_OKAY);
    axi_write(ADDR_STATUS, 8'h7F, RESP_OKAY);
    axi_read(ADDR_STATUS, 32'h0, 32'hE6, RESP_OKAY);
    repeat (2) @(negedge clk);
    check({31'h0, irq}, 32'h0);
    axi_write(ADDR_MASK, 8'h00, RESP_OKAY);
    ts16Zero <= 1'h1;
    n = 0;
    while (txMfCount !== 4'h2 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    repeat (20) @(negedge clk);
    check({31'h0, irq}, 32'h0);
    axi_read(ADDR_STATUS, 32'h3F, 32'h7F, RESP_OKAY);
    check({24'h0, txSaSeen[0]}, {24'h0, txCode});
    check({24'h0, txSaSeen[1]}, 32'h55);
    check({24'h0, txSaSeen[4]}, 32'hFF);
    check(linkPulses, 32'd16);
    check({24'h0, linkShift}, {24'h0, rxCode});
    test_done();
  end
endmodule
